// ==== core/hia_top.sv ====
// host interrupt aggregator: pending flags, enables, low-power event status,
// active-low interrupt pin toward the host.
// assumes: events and register port are synchronous to clk_sys, pulses one cycle.
`include "hia_map.svh"

module hia_top (
   input  wire logic             clk_sys,
   input  wire logic             srst,
   input  wire hia_pkg::hia_bus_s bus,
   input  wire hia_pkg::hia_evt_s evt,
   output logic [`HIA_DW-1:0]    rdata_q,
   output logic                  int_n_q
);
   import hia_pkg::*;

   function automatic logic hit(input hia_addr_t a, input hia_addr_t reg_addr);
      hit = (a == reg_addr);
   endfunction

   function automatic logic any_set(input hia_data_t v);
      any_set = |v;
   endfunction

   hia_data_t st0_q;
   hia_data_t st0_d;
   hia_data_t st1_q;
   hia_data_t st1_d;
   hia_data_t en0_q;
   hia_data_t en1_q;
   hia_data_t lpst_q;
   hia_data_t lpst_d;
   hia_data_t lpmask_q;
   hia_data_t set0;
   hia_data_t set1;
   hia_data_t lpset;
   hia_data_t clr0;
   hia_data_t clr1;
   hia_data_t rd_mux;
   logic      rd_st0;
   logic      rd_st1;
   logic      pend;

   assign rd_st0 = bus.rd && hit(bus.addr, `HIA_ADDR_ST0);
   assign rd_st1 = bus.rd && hit(bus.addr, `HIA_ADDR_ST1);

   // flags latch whatever the enables say; enables gate the pin and the low-power status record
   always_comb begin
      set0 = `HIA_ZERO8;
      set0[`HIA_B_ALARM]   = evt.alarm;
      set0[`HIA_B_OSCFAIL] = evt.osc_fail;
      set0[`HIA_B_PMATCH]  = evt.port_match;
      set1 = `HIA_ZERO8;
      set1[`HIA_B_RSTDONE] = evt.reset_done;
      set1[`HIA_B_TMR1]    = evt.tmr1_ovf | evt.rtc_capture;
      set1[`HIA_B_TMR0]    = evt.tmr0_ovf;
   end

   // rtc flags survive the clearing read while low-power status holds anything
   always_comb begin
      clr0 = `HIA_ZERO8;
      if (rd_st0) begin
         clr0 = `HIA_USED0;
         if (any_set(lpst_q)) begin
            clr0 = `HIA_USED0 & ~`HIA_RTC_BITS;
         end
      end
      clr1 = rd_st1 ? `HIA_USED1 : `HIA_ZERO8;
   end

   // set ORed in after the clear so a same-cycle event is never lost
   assign st0_d = (st0_q & ~clr0) | set0;
   assign st1_d = (st1_q & ~clr1) | set1;

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         st0_q <= `HIA_RST_ST0;
         st1_q <= `HIA_RST_ST1;
      end else begin
         st0_q <= st0_d;
         st1_q <= st1_d;
      end
   end

   // low-power status: write one to clear, a new event wins over the clear
   always_comb begin
      lpset = `HIA_ZERO8;
      lpset[`HIA_B_ALARM]   = evt.alarm && en0_q[`HIA_B_ALARM];
      lpset[`HIA_B_OSCFAIL] = evt.osc_fail && en0_q[`HIA_B_OSCFAIL];
      lpst_d = lpst_q;
      if (bus.wr && hit(bus.addr, `HIA_ADDR_LPST)) begin
         lpst_d = lpst_q & ~bus.wdata;
      end
      lpst_d = lpst_d | lpset;
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         lpst_q <= `HIA_RST_LPST;
      end else begin
         lpst_q <= lpst_d;
      end
   end

   // enable and mask registers
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         en0_q    <= `HIA_RST_EN0;
         en1_q    <= `HIA_RST_EN1;
         lpmask_q <= `HIA_RST_LPMASK;
      end else if (bus.wr) begin
         if (hit(bus.addr, `HIA_ADDR_EN0)) begin
            en0_q <= bus.wdata;
         end
         if (hit(bus.addr, `HIA_ADDR_EN1)) begin
            en1_q <= bus.wdata & `HIA_USED1;
         end
         if (hit(bus.addr, `HIA_ADDR_LPMASK)) begin
            lpmask_q <= bus.wdata & `HIA_RTC_BITS;
         end
      end
   end

   always_comb begin
      case (bus.addr)
         `HIA_ADDR_EN0:    rd_mux = en0_q | `HIA_EN0_ONES;
         `HIA_ADDR_EN1:    rd_mux = en1_q;
         `HIA_ADDR_LPMASK: rd_mux = lpmask_q;
         `HIA_ADDR_MIR0:   rd_mux = st0_q;
         `HIA_ADDR_MIR1:   rd_mux = st1_q;
         `HIA_ADDR_LPST:   rd_mux = lpst_q;
         `HIA_ADDR_ST0:    rd_mux = st0_q;
         `HIA_ADDR_ST1:    rd_mux = st1_q;
         default:          rd_mux = `HIA_RD_UNMAPPED;
      endcase
   end

   // read data stands only in the cycle after the strobe
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         rdata_q <= `HIA_ZERO8;
      end else if (bus.rd) begin
         rdata_q <= rd_mux;
      end else begin
         rdata_q <= `HIA_ZERO8;
      end
   end

   // pin follows the registered flags one cycle later; a glitch-free pin
   // was worth more than that cycle of latency
   assign pend = any_set(st0_q & en0_q & `HIA_USED0)
              || any_set(st1_q & en1_q & `HIA_USED1)
              || any_set(lpst_q & lpmask_q);

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         int_n_q <= 1'b1;
      end else begin
         int_n_q <= ~pend;
      end
   end

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (srst);

   chk_alarm_flag_set: assert property (
      evt.alarm |=> st0_q[`HIA_B_ALARM])
      else $error("alarm did not set status 0 bit 4");

   chk_oscfail_flag_set: assert property (
      evt.osc_fail |=> st0_q[`HIA_B_OSCFAIL])
      else $error("oscillator fail did not set status 0 bit 3");

   chk_pmatch_flag_set: assert property (
      evt.port_match |=> st0_q[`HIA_B_PMATCH])
      else $error("port match did not set status 0 bit 0");

   chk_rstdone_flag_set: assert property (
      evt.reset_done |=> st1_q[`HIA_B_RSTDONE])
      else $error("reset complete did not set status 1 bit 4");

   chk_tmr1_flag_set: assert property (
      (evt.tmr1_ovf || evt.rtc_capture) |=> st1_q[`HIA_B_TMR1])
      else $error("timer 1 or capture did not set status 1 bit 3");

   chk_tmr0_flag_set: assert property (
      evt.tmr0_ovf |=> st1_q[`HIA_B_TMR0])
      else $error("timer 0 did not set status 1 bit 2");

   chk_read_clears_st1: assert property (
      (rd_st1 && set1 == `HIA_ZERO8) |=> st1_q == `HIA_ZERO8)
      else $error("status 1 not cleared by its read");

   chk_read_clears_st0: assert property (
      (rd_st0 && !any_set(lpst_q) && set0 == `HIA_ZERO8) |=> st0_q == `HIA_ZERO8)
      else $error("status 0 not cleared by its read");

   chk_read_returns_st0: assert property (
      rd_st0 |=> rdata_q == $past(st0_q))
      else $error("status 0 read returned wrong data");

   chk_rtc_flag_hold: assert property (
      (rd_st0 && any_set(lpst_q) && st0_q[`HIA_B_ALARM]) |=> st0_q[`HIA_B_ALARM])
      else $error("alarm flag cleared while low-power status set");

   chk_mirror_no_clear: assert property (
      (bus.rd && hit(bus.addr, `HIA_ADDR_MIR0)) |=> (st0_q & $past(st0_q)) == $past(st0_q))
      else $error("mirror read cleared a flag");

   chk_lp_record: assert property (
      (evt.alarm && en0_q[`HIA_B_ALARM]) |=> lpst_q[`HIA_B_ALARM])
      else $error("alarm not recorded in low-power status");

   chk_set_beats_clear: assert property (
      (rd_st0 && evt.port_match) |=> st0_q[`HIA_B_PMATCH])
      else $error("event lost against clearing read");

   chk_pin_asserts: assert property (
      (evt.port_match && en0_q[`HIA_B_PMATCH]) |=> ##1 !int_n_q)
      else $error("enabled event did not pull the pin low");

   chk_pin_releases: assert property (
      !pend |=> int_n_q)
      else $error("pin low with nothing pending");

   chk_pin_masked: assert property (
      (!any_set(lpst_q & lpmask_q) && !any_set(st1_q & en1_q)
       && !any_set(st0_q & en0_q & `HIA_USED0)) |=> int_n_q)
      else $error("disabled source drove the pin");

   // register port: read data and stored values show one cycle after the strobe
   chk_read_returns_st1: assert property (
      rd_st1 |=> rdata_q == $past(st1_q))
      else $error("status 1 read returned wrong data");

   chk_pm_flag_clears: assert property (
      (rd_st0 && !evt.port_match) |=> !st0_q[`HIA_B_PMATCH])
      else $error("port match flag survived its clearing read");

   chk_rdata_idle: assert property (
      !bus.rd |=> rdata_q == `HIA_ZERO8)
      else $error("read data stood outside its cycle");

   chk_pin_holds: assert property (
      pend |=> !int_n_q)
      else $error("pin released with an enabled flag pending");

   chk_flag_sticky: assert property (
      (!rd_st1 && st1_q[`HIA_B_TMR0]) |=> st1_q[`HIA_B_TMR0])
      else $error("timer 0 flag dropped without a clearing read");

   chk_oscfail_lp_record: assert property (
      (evt.osc_fail && en0_q[`HIA_B_OSCFAIL]) |=> lpst_q[`HIA_B_OSCFAIL])
      else $error("oscillator fail not recorded in low-power status");

   chk_oscfail_flag_hold: assert property (
      (rd_st0 && any_set(lpst_q) && st0_q[`HIA_B_OSCFAIL]) |=> st0_q[`HIA_B_OSCFAIL])
      else $error("oscillator fail flag cleared while low-power status set");

   chk_mirror1_no_clear: assert property (
      (bus.rd && hit(bus.addr, `HIA_ADDR_MIR1)) |=> (st1_q & $past(st1_q)) == $past(st1_q))
      else $error("mirror 1 read cleared a flag");

   chk_mirror0_data: assert property (
      (bus.rd && hit(bus.addr, `HIA_ADDR_MIR0)) |=> rdata_q == $past(st0_q))
      else $error("mirror 0 read returned wrong data");

   chk_mirror1_data: assert property (
      (bus.rd && hit(bus.addr, `HIA_ADDR_MIR1)) |=> rdata_q == $past(st1_q))
      else $error("mirror 1 read returned wrong data");

   chk_en0_write: assert property (
      (bus.wr && hit(bus.addr, `HIA_ADDR_EN0)) |=> en0_q == $past(bus.wdata))
      else $error("enable 0 write not stored");

   chk_en1_write: assert property (
      (bus.wr && hit(bus.addr, `HIA_ADDR_EN1)) |=> en1_q == ($past(bus.wdata) & `HIA_USED1))
      else $error("enable 1 write not stored");

   chk_en0_read: assert property (
      (bus.rd && hit(bus.addr, `HIA_ADDR_EN0)) |=> rdata_q == ($past(en0_q) | `HIA_EN0_ONES))
      else $error("enable 0 read returned wrong data");

   chk_en1_read: assert property (
      (bus.rd && hit(bus.addr, `HIA_ADDR_EN1)) |=> rdata_q == $past(en1_q))
      else $error("enable 1 read returned wrong data");

endmodule

// ==== core/hia_map.svh ====
// register map, bit positions and reset values of the host interrupt aggregator
// assumes: 8-bit register address space, 8-bit data
`ifndef HIA_MAP_SVH
`define HIA_MAP_SVH

`define HIA_AW              8
`define HIA_DW              8

`define HIA_ADDR_EN0        8'h30
`define HIA_ADDR_EN1        8'h31
`define HIA_ADDR_LPMASK     8'h35
`define HIA_ADDR_MIR0       8'h40
`define HIA_ADDR_MIR1       8'h41
`define HIA_ADDR_LPST       8'h42
`define HIA_ADDR_ST0        8'h43
`define HIA_ADDR_ST1        8'h44

`define HIA_B_ALARM         4
`define HIA_B_OSCFAIL       3
`define HIA_B_PMATCH        0
`define HIA_B_RSTDONE       4
`define HIA_B_TMR1          3
`define HIA_B_TMR0          2

`define HIA_USED0           8'h19
`define HIA_USED1           8'h1C
`define HIA_RTC_BITS        8'h18
`define HIA_EN0_ONES        8'hC6

`define HIA_RST_ST0         8'h00
`define HIA_RST_ST1         8'h04
`define HIA_RST_EN0         8'hF6
`define HIA_RST_EN1         8'h00
`define HIA_RST_LPST        8'h00
`define HIA_RST_LPMASK      8'h00
`define HIA_RD_UNMAPPED     8'h00
`define HIA_ZERO8           8'h00

`endif

// ==== core/hia_pkg.sv ====
// types shared by the host interrupt aggregator and its bench
// assumes: hia_map.svh on the include path
`include "hia_map.svh"

package hia_pkg;

   typedef logic [`HIA_AW-1:0] hia_addr_t;
   typedef logic [`HIA_DW-1:0] hia_data_t;

   // register port request, all fields valid in one cycle
   typedef struct packed {
      hia_addr_t addr;
      hia_data_t wdata;
      logic      wr;
      logic      rd;
   } hia_bus_s;

   // one-cycle event pulses from the surrounding device logic
   typedef struct packed {
      logic alarm;
      logic osc_fail;
      logic port_match;
      logic reset_done;
      logic tmr1_ovf;
      logic rtc_capture;
      logic tmr0_ovf;
   } hia_evt_s;

endpackage

// ==== test/hia_host.sv ====
// host-side register master model for the interrupt aggregator bench
// assumes: one clock, read data stands one cycle after the read strobe
module hia_host (
   input  wire logic             clk_sys,
   output hia_pkg::hia_bus_s     bus
);
   timeunit 1ns;
   timeprecision 1ps;
   import hia_pkg::*;

   hia_data_t exp_q[$];

   initial bus = '0;

   task automatic wr(input hia_addr_t a, input hia_data_t d);
      @(posedge clk_sys);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk_sys);
      bus <= '0;
   endtask

   // expectation is noted before the strobe so the watcher never runs dry
   task automatic rd(input hia_addr_t a, input hia_data_t e);
      exp_q.push_back(e);
      @(posedge clk_sys);
      bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk_sys);
      bus <= '0;
   endtask

   // rtc flags stay pinned while low-power status holds them, so that goes first
   task automatic clr_rd(input hia_addr_t a, input hia_data_t e);
      wr(8'h42, 8'hFF);
      rd(a, e);
   endtask
endmodule

// ==== test/hia_top_test.sv ====
// self-checking bench of the host interrupt aggregator
// assumes: hia_host drives the register port, events come from here
module hia_top_test;
   timeunit 1ns;
   timeprecision 1ps;
   import hia_pkg::*;

   logic      clk_sys;
   logic      srst;
   hia_bus_s  bus;
   hia_evt_s  evt;
   hia_data_t rdata_q;
   logic      int_n_q;
   int        num_errors;
   int        tests_run;
   logic      rd_pend;
   hia_data_t r;
   hia_addr_t a;
   hia_data_t msk;

   hia_host host (.clk_sys(clk_sys), .bus(bus));

   hia_top dut (.clk_sys(clk_sys), .srst(srst), .bus(bus), .evt(evt),
                .rdata_q(rdata_q), .int_n_q(int_n_q));

   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end

   task automatic check(input logic [7:0] seen, input logic [7:0] want);
      tests_run++;
      if (seen !== want) begin
         num_errors++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, want);
      end
   endtask

   task automatic end_of_test();
      $display("errors %0d of %0d comparisons", num_errors, tests_run);
      if (num_errors == 0 && tests_run > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   function automatic hia_data_t lfsr(input hia_data_t s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction

   // read data belongs to the strobe seen one edge earlier
   always @(posedge clk_sys) begin
      if (rd_pend)
         check(rdata_q, host.exp_q.pop_front());
      rd_pend = bus.rd;
   end

   task automatic pulse(input logic [6:0] v);
      @(posedge clk_sys);
      evt <= hia_evt_s'(v);
      @(posedge clk_sys);
      evt <= '0;
   endtask

   // bounded wait for the pin; a level never reached shows as a mismatch
   task automatic wait_pin(input logic lvl);
      for (int i = 0; i < 6 && int_n_q !== lvl; i++)
         @(posedge clk_sys);
      check({7'h00, int_n_q}, {7'h00, lvl});
      if (int_n_q !== lvl)
         end_of_test();
   endtask

   initial begin
      repeat (20000) @(posedge clk_sys);
      num_errors++;
      end_of_test();
   end

   initial begin
      num_errors = 0;
      tests_run = 0;
      rd_pend = 1'b0;
      evt = '0;
      srst = 1'b1;
      r = 8'h10;
      repeat (5) @(posedge clk_sys);
      srst <= 1'b0;
      check({7'h00, int_n_q}, 8'h01);
      host.rd(8'h30, 8'hF6);
      host.rd(8'h31, 8'h00);
      host.rd(8'h40, 8'h00);
      host.rd(8'h41, 8'h04);
      host.rd(8'h44, 8'h04);
      host.rd(8'h41, 8'h00);
      host.rd(8'h50, 8'h00);
      for (int k = 0; k < 4; k++) begin
         r = lfsr(r);
         host.wr(8'h30, r);
         host.rd(8'h30, r | 8'hC6);
         host.wr(8'h31, r);
         host.rd(8'h31, r & 8'h1C);
      end
      host.wr(8'h30, 8'h19);
      host.wr(8'h31, 8'h1C);
      wait_pin(1'b1);
      // struct order: alarm, osc fail, port match, reset done, tmr1, capture, tmr0
      for (int i = 6; i >= 0; i--) begin
         a = (i >= 4) ? 8'h43 : 8'h44;
         msk = (i == 6 || i == 3) ? 8'h10 : (i == 4) ? 8'h01 : (i == 0) ? 8'h04 : 8'h08;
         pulse(7'(1 << i));
         wait_pin(1'b0);
         host.rd(a - 8'h03, msk);
         host.rd(a - 8'h03, msk);
         if (i >= 5) begin
            host.rd(a, msk);
            host.rd(8'h40, msk);
            host.rd(8'h42, msk);
         end
         host.clr_rd(a, msk);
         host.rd(a - 8'h03, 8'h00);
         wait_pin(1'b1);
      end
      host.wr(8'h31, 8'h18);
      pulse(7'h01);
      repeat (4) @(posedge clk_sys);
      check({7'h00, int_n_q}, 8'h01);
      host.rd(8'h41, 8'h04);
      host.wr(8'h31, 8'h1C);
      wait_pin(1'b0);
      host.rd(8'h44, 8'h04);
      wait_pin(1'b1);
      fork
         host.rd(8'h43, 8'h00);
         pulse(7'h10);
      join
      host.rd(8'h40, 8'h01);
      host.rd(8'h43, 8'h01);
      wait_pin(1'b1);
      // low-power status alone holds the pin once its mask is open
      host.wr(8'h35, 8'hFF);
      host.rd(8'h35, 8'h18);
      pulse(7'h40);
      wait_pin(1'b0);
      host.wr(8'h30, 8'h01);
      host.rd(8'h43, 8'h10);
      host.rd(8'h42, 8'h10);
      repeat (2) @(posedge clk_sys);
      check({7'h00, int_n_q}, 8'h00);
      host.wr(8'h42, 8'hFF);
      wait_pin(1'b1);
      host.rd(8'h43, 8'h10);
      host.wr(8'h35, 8'h00);
      host.wr(8'h30, 8'h19);
      // reset in mid-run with the pin low must release it
      pulse(7'h01);
      wait_pin(1'b0);
      @(posedge clk_sys);
      srst <= 1'b1;
      repeat (2) @(posedge clk_sys);
      srst <= 1'b0;
      check({7'h00, int_n_q}, 8'h01);
      host.rd(8'h41, 8'h04);
      host.rd(8'h30, 8'hF6);
      host.rd(8'h31, 8'h00);
      wait_pin(1'b1);
      repeat (3) @(posedge clk_sys);
      end_of_test();
   end
endmodule
